//--- rtl/dbg_trace_pkg.sv
// shared constants and types for the debug command and opcode trace block
package dbg_trace_pkg;

  // command opcodes
  localparam logic [15:0] OPC_CALL = 16'h0800;
  localparam logic [15:0] OPC_PERIPH_RST = 16'h0400;
  localparam logic [15:0] OPC_NULL = 16'h0000;

  // 17-bit status words loaded into the serial shifter
  localparam logic [16:0] RESP_COMPLETE = 17'h0ffff;
  localparam logic [16:0] RESP_CMD_RESPONSE_A = 17'h1ffff;
  localparam logic [16:0] RESP_BUS_ERR = 17'h10001;

  // peripheral reset pulse length in clock cycles
  localparam int PERIPH_RESET_CYCLES = 512;
  localparam int RST_CNT_W = 10;
  localparam logic [RST_CNT_W-1:0] RST_CNT_LOAD = RST_CNT_W'(PERIPH_RESET_CYCLES - 1);
  localparam logic [RST_CNT_W-1:0] RST_CNT_ZERO = 10'h000;

  // return address push size in bytes
  localparam logic [31:0] STACK_STEP = 32'h0000_0004;

  // trace pin pulse widths in clocks
  localparam int MARK_W = 3;
  localparam logic [MARK_W-1:0] MARK_NONE = 3'h0;
  localparam logic [MARK_W-1:0] MARK_ONE = 3'h1;
  localparam logic [MARK_W-1:0] MARK_TWO = 3'h2;
  localparam logic [MARK_W-1:0] MARK_MAX = 3'h7;

  typedef struct packed {
    logic [15:0] opcode;
    logic [31:0] operand;
  } dbg_cmd_t;

  typedef struct packed {
    logic valid;
    logic [15:0] word;
  } stage_t;

  typedef struct packed {
    logic req;
    logic [31:0] addr;
    logic [31:0] data;
  } stack_wr_t;

  typedef struct packed {
    logic done;
    logic err;
    logic addr_err;
    logic [15:0] word;
  } fetch_bus_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_STACK = 2'b01,
    ST_PERIPH_RST = 2'b10,
    ST_FIRST_FETCH = 2'b11
  } cmd_state_t;

endpackage

//--- rtl/periph_reset_timer.sv
// fixed-length peripheral reset pulse generator
`timescale 1ns/10ps
`default_nettype none
module periph_reset_timer
  import dbg_trace_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic start,
  output logic reset_out_n,
  output logic done
);

  logic active_ff;
  logic [RST_CNT_W-1:0] cnt_ff;
  logic rst_n_ff;
  logic done_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      active_ff <= 1'b0;
      cnt_ff <= RST_CNT_ZERO;
    end else if (clk_en) begin
      if (start && !active_ff) begin
        active_ff <= 1'b1;
        cnt_ff <= RST_CNT_LOAD;
      end else if (active_ff) begin
        if (cnt_ff == RST_CNT_ZERO) begin
          active_ff <= 1'b0;
        end else begin
          cnt_ff <= cnt_ff - 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_n_ff <= 1'b1;
      done_ff <= 1'b0;
    end else if (clk_en) begin
      rst_n_ff <= !((start && !active_ff) || (active_ff && cnt_ff != RST_CNT_ZERO));
      done_ff <= active_ff && cnt_ff == RST_CNT_ZERO;
    end
  end

  assign reset_out_n = rst_n_ff;
  assign done = done_ff;

endmodule
`default_nettype wire

//--- rtl/dbg_opcode_trace.sv
// debug command tail (call, peripheral reset, null, cmd_response_a) and opcode trace pins
`timescale 1ns/10ps
`default_nettype none
module dbg_opcode_trace
  import dbg_trace_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic CLK_EN,
  input wire logic DEBUG_ENTER,
  output logic DEBUG_ACTIVE,
  input wire logic CMD_VALID,
  input wire dbg_cmd_t CMD,
  output logic CMD_READY,
  output logic RESP_VALID,
  output logic [16:0] RESP_DATA,
  input wire logic [31:0] RETURN_PC,
  input wire logic [31:0] STACK_PTR,
  output stack_wr_t STACK_WR,
  input wire logic STACK_DONE,
  input wire logic STACK_ERR,
  output logic PC_LOAD,
  output logic [31:0] PC_VALUE,
  output logic EXC_REQ,
  output logic EXC_ADDR_ERR,
  output logic [31:0] FAULT_ADDR,
  output logic PERIPH_RESET_N,
  input wire logic FETCH_START,
  input wire fetch_bus_t FETCH,
  input wire logic FLUSH_REQ,
  input wire logic ADV_USE,
  input wire logic ADV_NEW,
  input wire logic LOOP_RECIRC,
  output logic FETCH_IND_N,
  output logic PIPE_ADV_N,
  output stage_t BUF_STAGE,
  output stage_t DEC_STAGE,
  output stage_t EXE_STAGE
);

  // remaining low clocks plus a new mark, saturating
  function automatic logic [MARK_W-1:0] extend_mark(input logic [MARK_W-1:0] rem, input logic [MARK_W-1:0] mark);
    logic [MARK_W:0] sum;
    sum = {1'b0, (rem == MARK_NONE) ? MARK_NONE : rem - MARK_ONE} + {1'b0, mark};
    extend_mark = (sum > {1'b0, MARK_MAX}) ? MARK_MAX : sum[MARK_W-1:0];
  endfunction

  cmd_state_t state_ff;
  logic debug_ff;
  logic [31:0] operand_ff;
  logic resp_valid_ff;
  logic [16:0] resp_data_ff;
  stack_wr_t stack_wr_ff;
  logic pc_load_ff;
  logic [31:0] pc_value_ff;
  logic exc_req_ff;
  logic exc_addr_err_ff;
  logic [31:0] fault_addr_ff;
  logic call_flush_ff;
  logic rst_start;
  logic rst_done;
  logic cmd_take;
  logic flush_now;
  logic fetch_event;
  logic flush_pend_ff;
  logic [MARK_W-1:0] fetch_rem_ff;
  logic [MARK_W-1:0] nxt_fetch_rem;
  logic fetch_ind_n_ff;
  logic [MARK_W-1:0] pipe_rem_ff;
  logic [MARK_W-1:0] nxt_pipe_rem;
  logic [MARK_W-1:0] pipe_mark;
  logic pipe_adv_n_ff;
  stage_t buf_ff;
  stage_t dec_ff;
  stage_t exe_ff;
  stage_t nxt_buf;
  stage_t nxt_dec;
  stage_t nxt_exe;
  logic [10:0] rst_low_cnt_ff;

  assign cmd_take = CLK_EN && CMD_VALID && debug_ff && state_ff == ST_IDLE;
  assign rst_start = cmd_take && CMD.opcode == OPC_PERIPH_RST;

  periph_reset_timer periph_reset_timer_i (
    .clk(CORE_CLK),
    .rst_n(RST_N),
    .clk_en(CLK_EN),
    .start(rst_start),
    .reset_out_n(PERIPH_RESET_N),
    .done(rst_done)
  );

  // command sequencing
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_ff <= ST_IDLE;
      operand_ff <= 32'h0000_0000;
    end else if (CLK_EN) begin
      unique case (state_ff)
        ST_IDLE: begin
          if (cmd_take && CMD.opcode == OPC_CALL) begin
            state_ff <= ST_STACK;
            operand_ff <= CMD.operand;
          end else if (rst_start) begin
            state_ff <= ST_PERIPH_RST;
          end
        end
        ST_STACK: begin
          if (STACK_DONE) begin
            state_ff <= STACK_ERR ? ST_IDLE : ST_FIRST_FETCH;
          end
        end
        ST_PERIPH_RST: begin
          if (rst_done) begin
            state_ff <= ST_IDLE;
          end
        end
        ST_FIRST_FETCH: begin
          if (FETCH.done) begin
            state_ff <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // debug mode flag
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      debug_ff <= 1'b0;
    end else if (CLK_EN) begin
      if (DEBUG_ENTER) begin
        debug_ff <= 1'b1;
      end else if (state_ff == ST_FIRST_FETCH && FETCH.done) begin
        debug_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      stack_wr_ff <= '0;
    end else if (CLK_EN) begin
      if (cmd_take && CMD.opcode == OPC_CALL) begin
        stack_wr_ff.req <= 1'b1;
        stack_wr_ff.addr <= STACK_PTR - STACK_STEP;
        stack_wr_ff.data <= RETURN_PC;
      end else if (state_ff == ST_STACK && STACK_DONE) begin
        stack_wr_ff.req <= 1'b0;
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      pc_load_ff <= 1'b0;
      pc_value_ff <= 32'h0000_0000;
      call_flush_ff <= 1'b0;
    end else if (CLK_EN) begin
      pc_load_ff <= state_ff == ST_STACK && STACK_DONE && !STACK_ERR;
      call_flush_ff <= state_ff == ST_STACK && STACK_DONE && !STACK_ERR;
      if (state_ff == ST_STACK && STACK_DONE && !STACK_ERR) begin
        pc_value_ff <= operand_ff;
      end
    end
  end

  // fault on first prefetch from new pc
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      exc_req_ff <= 1'b0;
      exc_addr_err_ff <= 1'b0;
      fault_addr_ff <= 32'h0000_0000;
    end else if (CLK_EN) begin
      exc_req_ff <= state_ff == ST_FIRST_FETCH && FETCH.done && FETCH.err;
      if (state_ff == ST_FIRST_FETCH && FETCH.done && FETCH.err) begin
        exc_addr_err_ff <= FETCH.addr_err;
        fault_addr_ff <= operand_ff;
      end
    end
  end

  // status word to the serial shifter
  // complete word after peripheral reset and null commands, none after a successful call
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      resp_valid_ff <= 1'b0;
      resp_data_ff <= RESP_COMPLETE;
    end else if (CLK_EN) begin
      resp_valid_ff <= 1'b0;
      if (state_ff == ST_STACK && STACK_DONE && STACK_ERR) begin
        resp_valid_ff <= 1'b1;
        resp_data_ff <= RESP_BUS_ERR;
      end else if (state_ff == ST_PERIPH_RST && rst_done) begin
        resp_valid_ff <= 1'b1;
        resp_data_ff <= RESP_COMPLETE;
      end else if (cmd_take && CMD.opcode != OPC_CALL && CMD.opcode != OPC_PERIPH_RST) begin
        resp_valid_ff <= 1'b1;
        if (CMD.opcode == OPC_NULL) begin
          resp_data_ff <= RESP_COMPLETE;
        end else begin
          resp_data_ff <= RESP_CMD_RESPONSE_A;
        end
      end
    end
  end

  assign flush_now = FLUSH_REQ || call_flush_ff;
  // no fetch marks while words recirculate
  assign fetch_event = FETCH_START && !LOOP_RECIRC;

  // flush pending until next marked fetch
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      flush_pend_ff <= 1'b0;
    end else if (CLK_EN) begin
      if (flush_now) begin
        flush_pend_ff <= 1'b1;
      end else if (fetch_event) begin
        flush_pend_ff <= 1'b0;
      end
    end
  end

  // one clock per fetch, two after flush
  always_comb begin
    nxt_fetch_rem = extend_mark(fetch_rem_ff,
                                fetch_event ? (flush_pend_ff ? MARK_TWO : MARK_ONE) : MARK_NONE);
  end

  // use and new start together stay asserted
  always_comb begin
    pipe_mark = MARK_NONE;
    if (ADV_NEW && ADV_USE) begin
      pipe_mark = MARK_TWO + MARK_ONE;
    end else if (ADV_NEW) begin
      pipe_mark = MARK_TWO;
    end else if (ADV_USE) begin
      pipe_mark = MARK_ONE;
    end
    nxt_pipe_rem = extend_mark(pipe_rem_ff, pipe_mark);
  end

  // trace pins driven from the core clock
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      fetch_rem_ff <= MARK_NONE;
      pipe_rem_ff <= MARK_NONE;
      fetch_ind_n_ff <= 1'b1;
      pipe_adv_n_ff <= 1'b1;
    end else if (CLK_EN) begin
      fetch_rem_ff <= nxt_fetch_rem;
      pipe_rem_ff <= nxt_pipe_rem;
      fetch_ind_n_ff <= nxt_fetch_rem == MARK_NONE;
      pipe_adv_n_ff <= nxt_pipe_rem == MARK_NONE;
    end
  end

  always_comb begin
    nxt_buf = buf_ff;
    nxt_dec = dec_ff;
    nxt_exe = exe_ff;
    if (flush_now) begin
      nxt_buf.valid = 1'b0;
      nxt_dec.valid = 1'b0;
      nxt_exe.valid = 1'b0;
    end else if (ADV_NEW) begin
      nxt_exe = dec_ff;
      nxt_dec = buf_ff;
      nxt_buf.valid = 1'b0;
    end else if (ADV_USE) begin
      nxt_dec = buf_ff;
      nxt_buf.valid = 1'b0;
    end
    if (FETCH.done && !FETCH.err) begin
      nxt_buf.valid = 1'b1;
      nxt_buf.word = FETCH.word;
    end
    if (!nxt_dec.valid && nxt_buf.valid) begin
      nxt_dec = nxt_buf;
      nxt_buf.valid = 1'b0;
    end
    if (!nxt_exe.valid && nxt_dec.valid) begin
      nxt_exe = nxt_dec;
      nxt_dec.valid = 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      buf_ff <= '0;
      dec_ff <= '0;
      exe_ff <= '0;
    end else if (CLK_EN) begin
      buf_ff <= nxt_buf;
      dec_ff <= nxt_dec;
      exe_ff <= nxt_exe;
    end
  end

  // low-time counter watched by the reset check
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_low_cnt_ff <= 11'h000;
    end else if (CLK_EN) begin
      rst_low_cnt_ff <= PERIPH_RESET_N ? 11'h000 : rst_low_cnt_ff + 11'h001;
    end
  end

  assign DEBUG_ACTIVE = debug_ff;
  assign CMD_READY = debug_ff && state_ff == ST_IDLE;
  assign RESP_VALID = resp_valid_ff;
  assign RESP_DATA = resp_data_ff;
  assign STACK_WR = stack_wr_ff;
  assign PC_LOAD = pc_load_ff;
  assign PC_VALUE = pc_value_ff;
  assign EXC_REQ = exc_req_ff;
  assign EXC_ADDR_ERR = exc_addr_err_ff;
  assign FAULT_ADDR = fault_addr_ff;
  assign FETCH_IND_N = fetch_ind_n_ff;
  assign PIPE_ADV_N = pipe_adv_n_ff;
  assign BUF_STAGE = buf_ff;
  assign DEC_STAGE = dec_ff;
  assign EXE_STAGE = exe_ff;

  a_call_push_addr: assert property (@(posedge CORE_CLK) disable iff (!RST_N || !CLK_EN)
    cmd_take && CMD.opcode == OPC_CALL |=>
      STACK_WR.req && STACK_WR.addr == $past(STACK_PTR) - STACK_STEP && STACK_WR.data == $past(RETURN_PC))
    else $error("call push address or data wrong");

  a_call_new_pc: assert property (@(posedge CORE_CLK) disable iff (!RST_N || !CLK_EN)
    state_ff == ST_STACK && STACK_DONE && !STACK_ERR |=> PC_LOAD && PC_VALUE == operand_ff ##1 !BUF_STAGE.valid)
    else $error("call did not load pc and flush");

  a_push_err_stay: assert property (@(posedge CORE_CLK) disable iff (!RST_N || !CLK_EN)
    state_ff == ST_STACK && STACK_DONE && STACK_ERR |=> RESP_VALID && RESP_DATA == RESP_BUS_ERR && DEBUG_ACTIVE)
    else $error("push error not reported");

  a_prefetch_exc: assert property (@(posedge CORE_CLK) disable iff (!RST_N || !CLK_EN)
    state_ff == ST_FIRST_FETCH && FETCH.done && FETCH.err |=> EXC_REQ && !DEBUG_ACTIVE && FAULT_ADDR == operand_ff)
    else $error("prefetch fault not trapped");

  a_reset_length: assert property (@(posedge CORE_CLK) disable iff (!RST_N || !CLK_EN)
    $rose(PERIPH_RESET_N) |-> rst_low_cnt_ff == 11'(PERIPH_RESET_CYCLES))
    else $error("peripheral reset length wrong");

  a_reset_resp: assert property (@(posedge CORE_CLK) disable iff (!RST_N || !CLK_EN)
    $rose(PERIPH_RESET_N) |-> ##[0:2] (RESP_VALID && RESP_DATA == RESP_COMPLETE))
    else $error("no complete status after reset");

  a_null_resp: assert property (@(posedge CORE_CLK) disable iff (!RST_N || !CLK_EN)
    cmd_take && CMD.opcode == OPC_NULL |=> RESP_VALID && RESP_DATA == RESP_COMPLETE && $stable(state_ff))
    else $error("null command response wrong");

  a_cmd_response_a_resp: assert property (@(posedge CORE_CLK) disable iff (!RST_N || !CLK_EN)
    cmd_take && CMD.opcode != OPC_NULL && CMD.opcode != OPC_CALL && CMD.opcode != OPC_PERIPH_RST
      |=> RESP_VALID && RESP_DATA == RESP_CMD_RESPONSE_A && state_ff == ST_IDLE)
    else $error("cmd_response_a command response wrong");

  a_fetch_single: assert property (@(posedge CORE_CLK) disable iff (!RST_N || !CLK_EN)
    fetch_event && !flush_pend_ff && !flush_now && fetch_rem_ff == MARK_NONE ##1 !FETCH_START
      |-> !FETCH_IND_N ##1 FETCH_IND_N)
    else $error("fetch mark not one clock");

  a_fetch_flush: assert property (@(posedge CORE_CLK) disable iff (!RST_N || !CLK_EN)
    fetch_event && flush_pend_ff && fetch_rem_ff == MARK_NONE ##1 !FETCH_START[*2]
      |-> !$past(FETCH_IND_N) && !FETCH_IND_N ##1 FETCH_IND_N)
    else $error("flush mark not two clocks");

  a_pipe_full: assert property (@(posedge CORE_CLK) disable iff (!RST_N || !CLK_EN)
    ADV_NEW && !ADV_USE && pipe_rem_ff == MARK_NONE ##1 !ADV_NEW && !ADV_USE ##1 !ADV_NEW && !ADV_USE
      |-> !$past(PIPE_ADV_N) && !PIPE_ADV_N ##1 PIPE_ADV_N)
    else $error("full advance not two clocks");

  a_use_refill: assert property (@(posedge CORE_CLK) disable iff (!RST_N || !CLK_EN)
    ADV_USE && !ADV_NEW && !flush_now && BUF_STAGE.valid |=> DEC_STAGE.valid && DEC_STAGE.word == $past(buf_ff.word))
    else $error("buffer word not moved to decode");

  a_loop_quiet: assert property (@(posedge CORE_CLK) disable iff (!RST_N || !CLK_EN)
    LOOP_RECIRC && fetch_rem_ff == MARK_NONE |=> FETCH_IND_N)
    else $error("fetch marked during recirculation");

endmodule
`default_nettype wire

//--- tb/dbg_host_model.sv
// core bus push responder and trace pin tracker facing the debug block
`timescale 1ns/10ps
`default_nettype none
module dbg_host_model
  import dbg_trace_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire stack_wr_t stack_wr,
  input wire logic [3:0] push_delay,
  input wire logic push_fail,
  output logic stack_done,
  output logic stack_err,
  input wire logic fetch_ind_n,
  input wire logic pipe_adv_n,
  output logic [3:0] fetch_run,
  output logic [3:0] adv_run
);
  logic [3:0] wait_ff;
  logic served_ff;
  logic [3:0] fcnt_ff;
  logic [3:0] acnt_ff;

  // push answered after a chosen delay, error only on command
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_ff <= 4'h0;
      served_ff <= 1'b0;
      stack_done <= 1'b0;
      stack_err <= 1'b0;
    end else begin
      stack_done <= 1'b0;
      stack_err <= 1'b0;
      if (!stack_wr.req) begin
        served_ff <= 1'b0;
        wait_ff <= 4'h0;
      end else if (!served_ff && wait_ff == push_delay) begin
        stack_done <= 1'b1;
        stack_err <= push_fail;
        served_ff <= 1'b1;
      end else if (!served_ff) begin
        wait_ff <= wait_ff + 4'h1;
      end
    end
  end

  // fetch mark length, rising edge sampling
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fcnt_ff <= 4'h0;
      fetch_run <= 4'h0;
    end else if (!fetch_ind_n) begin
      fcnt_ff <= fcnt_ff + 4'h1;
    end else if (fcnt_ff != 4'h0) begin
      fetch_run <= fcnt_ff;
      fcnt_ff <= 4'h0;
    end
  end

  // advance length, falling edge, resync when idle
  always_ff @(negedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acnt_ff <= 4'h0;
      adv_run <= 4'h0;
    end else if (!pipe_adv_n) begin
      acnt_ff <= acnt_ff + 4'h1;
    end else if (acnt_ff != 4'h0) begin
      adv_run <= acnt_ff;
      acnt_ff <= 4'h0;
    end
  end
endmodule
`default_nettype wire

//--- tb/dbg_opcode_trace_tb.sv
// self-checking bench for the debug command tail and trace pins
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin fail_count++; \
  $display("ERROR %s exp %0h got %0h", nm, e, g); end end
module dbg_opcode_trace_tb import dbg_trace_pkg::*;;
  logic CORE_CLK = 1'b0, RST_N = 1'b1, CLK_EN = 1'b1, DEBUG_ENTER = 1'b0, CMD_VALID = 1'b0;
  logic FETCH_START = 1'b0, FLUSH_REQ = 1'b0, ADV_USE = 1'b0, ADV_NEW = 1'b0, LOOP_RECIRC = 1'b0;
  logic DEBUG_ACTIVE, CMD_READY, RESP_VALID, PC_LOAD, EXC_REQ, EXC_ADDR_ERR, PERIPH_RESET_N;
  logic FETCH_IND_N, PIPE_ADV_N, STACK_DONE, STACK_ERR, push_fail = 1'b0;
  logic [16:0] RESP_DATA;
  logic [31:0] RETURN_PC = 32'h0000_1234, STACK_PTR = 32'h0000_2000, PC_VALUE, FAULT_ADDR;
  logic [3:0] push_delay = 4'h3, fetch_run, adv_run;
  dbg_cmd_t CMD = '0;
  fetch_bus_t FETCH = '0;
  stack_wr_t STACK_WR;
  stage_t BUF_STAGE, DEC_STAGE, EXE_STAGE;
  int fail_count = 0, checks = 0, cyc = 0, low_cnt = 0;

  dbg_opcode_trace dbg_opcode_trace_i (.CORE_CLK, .RST_N, .CLK_EN, .DEBUG_ENTER, .DEBUG_ACTIVE, .CMD_VALID,
    .CMD, .CMD_READY, .RESP_VALID, .RESP_DATA, .RETURN_PC, .STACK_PTR, .STACK_WR, .STACK_DONE, .STACK_ERR,
    .PC_LOAD, .PC_VALUE, .EXC_REQ, .EXC_ADDR_ERR, .FAULT_ADDR, .PERIPH_RESET_N, .FETCH_START, .FETCH,
    .FLUSH_REQ, .ADV_USE, .ADV_NEW, .LOOP_RECIRC, .FETCH_IND_N, .PIPE_ADV_N, .BUF_STAGE, .DEC_STAGE,
    .EXE_STAGE);
  dbg_host_model dbg_host_model_i (.clk(CORE_CLK), .rst_n(RST_N), .stack_wr(STACK_WR), .push_delay,
    .push_fail, .stack_done(STACK_DONE), .stack_err(STACK_ERR), .fetch_ind_n(FETCH_IND_N),
    .pipe_adv_n(PIPE_ADV_N), .fetch_run, .adv_run);

  always #2 CORE_CLK = ~CORE_CLK;

  always @(posedge CORE_CLK) begin
    cyc++;
    if (FETCH_IND_N === 1'b0) low_cnt++;
    if (cyc == 3000) begin
      fail_count++;
      $display("ERROR timeout");
      end_sim();
    end
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic tick(int n = 1);
    repeat (n) @(posedge CORE_CLK);
    #1;
  endtask

  task automatic send(logic [15:0] op, logic [31:0] arg);
    for (int i = 0; i < 20 && CMD_READY !== 1'b1; i++) tick();
    CMD_VALID = 1'b1;
    CMD = '{opcode: op, operand: arg};
    tick();
    CMD_VALID = 1'b0;
  endtask

  task automatic fetch(logic [15:0] w);
    FETCH_START = 1'b1;
    tick();
    FETCH_START = 1'b0;
    FETCH = '{done: 1'b1, err: 1'b0, addr_err: 1'b0, word: w};
    tick();
    FETCH = '0;
  endtask

  task automatic adv(logic u, logic n);
    ADV_USE = u;
    ADV_NEW = n;
    tick();
    ADV_USE = 1'b0;
    ADV_NEW = 1'b0;
  endtask

  task automatic t_reset();
    `CHK("stage_valids", 3'b000, {BUF_STAGE.valid, DEC_STAGE.valid, EXE_STAGE.valid})
    `CHK("trace_pins", 2'b11, {FETCH_IND_N, PIPE_ADV_N})
    $display("test reset done");
  endtask

  task automatic t_null_cmd_response_a();
    logic [15:0] ops [5] = '{16'h0000, 16'h0c00, 16'h1234, 16'hffff, 16'h0000};
    DEBUG_ENTER = 1'b1;
    tick();
    DEBUG_ENTER = 1'b0;
    tick();
    CMD_VALID = 1'b1;
    foreach (ops[i]) begin
      CMD = '{opcode: ops[i], operand: 32'hffff_ffff};
      tick();
      `CHK("resp_valid", 1'b1, RESP_VALID)
      `CHK("resp_data", ops[i] == 16'h0 ? RESP_COMPLETE : RESP_CMD_RESPONSE_A, RESP_DATA)
      `CHK("no_state", 4'b1100, {DEBUG_ACTIVE, PERIPH_RESET_N, STACK_WR.req, PC_LOAD})
    end
    CMD_VALID = 1'b0;
    tick();
    `CHK("resp_pulse", 1'b0, RESP_VALID)
    $display("test null_cmd_response_a done");
  endtask

  task automatic t_periph_rst();
    int n = 0;
    send(OPC_PERIPH_RST, 32'h0);
    while (PERIPH_RESET_N === 1'b0 && n < 600) begin
      n++;
      tick();
    end
    `CHK("reset_len", PERIPH_RESET_CYCLES, n)
    `CHK("cpu_kept", 1'b1, DEBUG_ACTIVE)
    `CHK("no_early_resp", 1'b0, RESP_VALID)
    tick();
    `CHK("resp_valid", 1'b1, RESP_VALID)
    `CHK("resp_data", RESP_COMPLETE, RESP_DATA)
    $display("test periph_rst done");
  endtask

  task automatic t_call_err();
    int n = 0;
    push_fail = 1'b1;
    send(OPC_CALL, 32'h0000_4001);
    `CHK("push_req", 1'b1, STACK_WR.req)
    `CHK("push_addr", STACK_PTR - STACK_STEP, STACK_WR.addr)
    `CHK("push_data", RETURN_PC, STACK_WR.data)
    `CHK("no_pc_yet", 1'b0, PC_LOAD)
    `CHK("busy", 1'b0, CMD_READY)
    tick();
    // offered while busy: must not be taken
    CMD_VALID = 1'b1;
    CMD = '{opcode: 16'h1234, operand: 32'h0};
    while (RESP_VALID !== 1'b1 && n < 20) begin
      n++;
      tick();
    end
    `CHK("err_status", RESP_BUS_ERR, RESP_DATA)
    `CHK("stay_debug", 1'b1, DEBUG_ACTIVE)
    CMD_VALID = 1'b0;
    push_fail = 1'b0;
    $display("test call_err done");
  endtask

  task automatic t_call_ok();
    int n = 0;
    push_delay = 4'h0;
    fetch(16'hc001);
    send(OPC_CALL, 32'h0000_4001);
    while (PC_LOAD !== 1'b1 && n < 20) begin
      n++;
      tick();
    end
    `CHK("pc_value", 32'h0000_4001, PC_VALUE)
    `CHK("no_resp", 1'b0, RESP_VALID)
    tick(2);
    `CHK("flushed", 3'b000, {BUF_STAGE.valid, DEC_STAGE.valid, EXE_STAGE.valid})
    FETCH_START = 1'b1;
    tick();
    FETCH_START = 1'b0;
    FETCH = '{done: 1'b1, err: 1'b1, addr_err: 1'b1, word: 16'h0};
    tick();
    FETCH = '0;
    `CHK("exc_req", 1'b1, EXC_REQ)
    `CHK("addr_err", 1'b1, EXC_ADDR_ERR)
    `CHK("fault_addr", 32'h0000_4001, FAULT_ADDR)
    `CHK("left_debug", 1'b0, DEBUG_ACTIVE)
    tick(3);
    `CHK("flush_mark", 4'h2, fetch_run)
    $display("test call_ok done");
  endtask

  task automatic t_pipeline();
    FLUSH_REQ = 1'b1;
    tick();
    FLUSH_REQ = 1'b0;
    fetch(16'ha001);
    fetch(16'ha002);
    fetch(16'ha003);
    `CHK("exe_fill", 17'h1a001, EXE_STAGE)
    `CHK("dec_fill", 17'h1a002, DEC_STAGE)
    `CHK("buf_fill", 17'h1a003, BUF_STAGE)
    adv(1'b1, 1'b0);
    `CHK("dec_use", 17'h1a003, DEC_STAGE)
    `CHK("buf_empty", 1'b0, BUF_STAGE.valid)
    `CHK("exe_kept", 17'h1a001, EXE_STAGE)
    tick(4);
    `CHK("use_run", 4'h1, adv_run)
    fetch(16'ha004);
    `CHK("buf_refill", 17'h1a004, BUF_STAGE)
    adv(1'b0, 1'b1);
    `CHK("exe_new", 17'h1a003, EXE_STAGE)
    `CHK("dec_new", 17'h1a004, DEC_STAGE)
    tick(4);
    `CHK("new_run", 4'h2, adv_run)
    adv(1'b1, 1'b1);
    `CHK("exe_both", 17'h1a004, EXE_STAGE)
    `CHK("dec_both", 1'b0, DEC_STAGE.valid)
    tick(5);
    `CHK("both_run", 4'h3, adv_run)
    $display("test pipeline done");
  endtask

  task automatic t_fetch_marks();
    int n;
    fetch(16'hb001);
    tick(3);
    `CHK("single_mark", 4'h1, fetch_run)
    FLUSH_REQ = 1'b1;
    tick();
    FLUSH_REQ = 1'b0;
    fetch(16'hb002);
    fetch(16'hb003);
    tick(3);
    `CHK("flush_then_fetch", 4'h3, fetch_run)
    n = low_cnt;
    LOOP_RECIRC = 1'b1;
    fetch(16'hb004);
    adv(1'b1, 1'b0);
    tick(4);
    `CHK("loop_quiet", n, low_cnt)
    `CHK("loop_adv", 4'h1, adv_run)
    LOOP_RECIRC = 1'b0;
    fetch(16'hb005);
    tick(3);
    `CHK("loop_exit", n + 1, low_cnt)
    $display("test fetch_marks done");
  endtask

  initial begin
    RST_N = 1'b0;
    repeat (8) @(posedge CORE_CLK);
    #1;
    RST_N = 1'b1;
    tick();
    t_reset();
    t_null_cmd_response_a();
    t_periph_rst();
    t_call_err();
    t_call_ok();
    t_pipeline();
    t_fetch_marks();
    end_sim();
  end
endmodule
`undef CHK
`default_nettype wire
